// ==== design/bit_fifo.sv ====
// small valid/ready fifo held in flip-flops
`timescale 1ns/100ps
`default_nettype none
module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, rd_r;
   logic [AW:0] cnt_r;
   logic push, pop;

   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("bit_fifo depth must be a power of two, at least 2");
   end

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage and pointers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
      end else begin
         if (push) begin
            mem_r[wr_r] <= in_data;
            wr_r <= wr_r + 1'b1;
         end
         if (pop) rd_r <= rd_r + 1'b1;
         if (push && !pop) cnt_r <= cnt_r + 1'b1;
         else if (pop && !push) cnt_r <= cnt_r - 1'b1;
      end
   end

   // never overflow, never underflow
   fifo_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
      cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count out of range");
endmodule : bit_fifo
`default_nettype wire

// ==== design/id_frame_consts.svh ====
// constants for the id frame transmitter: timing, frame layout, default content
`ifndef ID_FRAME_CONSTS_SVH
`define ID_FRAME_CONSTS_SVH
`define FRAME_BITS 64
`define HEADER_BITS 9
`define VERSION_BITS 8
`define PAYLOAD_BITS 32
`define STARTUP_WAIT_NOM 304
`define STARTUP_WAIT_MIN 250
`define STARTUP_WAIT_MAX 400
`define STOP_BIT_VALUE 1'b0
`define FIFO_DEPTH 4
`define VERSION_DEFAULT 8'hA5
`define PAYLOAD_DEFAULT 32'h1234ABCD
`endif

// ==== design/id_frame_pkg.sv ====
// types shared by the id frame transmitter
package id_frame_pkg;
   typedef struct packed {
      logic [7:0] version;
      logic [31:0] payload;
   } id_content_t;
   typedef enum logic [1:0] {st_wait, st_send} tx_state_t;
endpackage : id_frame_pkg

// ==== design/id_frame_tx.sv ====
// read-only id frame transmitter driven by the reader carrier
`timescale 1ns/100ps
`default_nettype none
`include "id_frame_consts.svh"
module id_frame_tx
#(
   parameter id_frame_pkg::id_content_t CONTENT =
      {`VERSION_DEFAULT, `PAYLOAD_DEFAULT},
   parameter int STARTUP_WAIT = `STARTUP_WAIT_NOM,
   parameter int BIT_PERIODS = 32,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic carrier_in,
   output logic field_load_r,
   output logic sending_r
);
   import id_frame_pkg::*;

   // -------------------------------------------------------------
   // parameter checks
   // -------------------------------------------------------------
   // refused at elaboration, so a bad build never reaches silicon
   if (STARTUP_WAIT < `STARTUP_WAIT_MIN ||
       STARTUP_WAIT > `STARTUP_WAIT_MAX) begin : g_bad_wait
      $error("startup wait outside 250..400 carrier periods");
   end
   if (BIT_PERIODS < 1 || BIT_PERIODS > 255) begin : g_bad_bits
      $error("bit periods out of range");
   end

   // -------------------------------------------------------------
   // frame assembly, constant at build time
   // -------------------------------------------------------------
   function automatic logic [63:0] build_frame(input id_content_t c);
      logic [63:0] f;
      logic [3:0] col;
      logic [3:0] nib;
      f = '0;
      col = '0;
      nib = '0;
      f[63:55] = 9'h1FF;
      f[54:50] = {c.version[7:4], ^c.version[7:4]};
      f[49:45] = {c.version[3:0], ^c.version[3:0]};
      for (int n = 0; n < 8; n++) begin
         nib = c.payload[31-4*n -: 4];
         f[44-5*n -: 5] = {nib, ^nib};
         col = col ^ nib;
      end
      f[4:0] = {col, `STOP_BIT_VALUE};
      return f;
   endfunction : build_frame

   localparam logic [63:0] FRAME = build_frame(CONTENT);

   // -------------------------------------------------------------
   // carrier sampling
   // -------------------------------------------------------------
   logic car_s1_r, car_s2_r, car_s3_r;
   logic car_rise;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         car_s1_r <= 1'b0;
         car_s2_r <= 1'b0;
         car_s3_r <= 1'b0;
      end else begin
         car_s1_r <= carrier_in;
         car_s2_r <= car_s1_r;
         car_s3_r <= car_s2_r;
      end
   end
   assign car_rise = car_s2_r && !car_s3_r;

   // -------------------------------------------------------------
   // startup wait and sequencer
   // -------------------------------------------------------------
   tx_state_t state_r;
   logic [8:0] wait_cnt_r;
   logic [5:0] bit_idx_r;
   logic in_valid, in_ready;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_r <= st_wait;
         wait_cnt_r <= '0;
      end else if (state_r == st_wait && car_rise) begin
         if (wait_cnt_r == 9'(STARTUP_WAIT - 1)) state_r <= st_send;
         else wait_cnt_r <= wait_cnt_r + 1'b1;
      end
   end

   assign in_valid = (state_r == st_send);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) bit_idx_r <= 6'h3F;
      else if (in_valid && in_ready) bit_idx_r <= bit_idx_r - 1'b1;
   end

   // -------------------------------------------------------------
   // bit buffer between sequencer and modulator
   // -------------------------------------------------------------
   logic out_valid, out_ready, out_bit;

   bit_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo (
      .mclk(mclk),
      .resetn(resetn),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(FRAME[bit_idx_r]),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_bit)
   );

   // -------------------------------------------------------------
   // modulator: one bit per BIT_PERIODS carrier periods
   // -------------------------------------------------------------
   logic [7:0] per_cnt_r;
   logic busy_r;

   // take a bit only when the previous bit time has ended
   assign out_ready = out_valid && (!busy_r ||
      (car_rise && per_cnt_r == 8'(BIT_PERIODS - 1)));

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busy_r <= 1'b0;
         per_cnt_r <= '0;
         field_load_r <= 1'b0;
         sending_r <= 1'b0;
      end else begin
         if (out_ready) begin
            busy_r <= 1'b1;
            per_cnt_r <= '0;
            field_load_r <= out_bit;
            sending_r <= 1'b1;
         end else if (busy_r && car_rise) begin
            if (per_cnt_r == 8'(BIT_PERIODS - 1)) begin
               busy_r <= 1'b0;
               field_load_r <= 1'b0;
            end else per_cnt_r <= per_cnt_r + 1'b1;
         end
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   // no bit before wait ends
   wait_first_a: assert property (@(posedge mclk)
      disable iff (!resetn) state_r == st_wait |-> !sending_r)
      else $error("bit sent early");

   sequence frame_wrap_s;
      in_valid && in_ready && bit_idx_r == 6'h00;
   endsequence
   frame_wrap_a: assert property (@(posedge mclk)
      disable iff (!resetn) frame_wrap_s |=> bit_idx_r == 6'h3F)
      else $error("frame did not wrap");

   keep_send_a: assert property (@(posedge mclk)
      disable iff (!resetn) state_r == st_send |=> state_r == st_send)
      else $error("send stopped");

   send_hold_a: assert property (@(posedge mclk)
      disable iff (!resetn) sending_r |=> sending_r)
      else $error("sending flag dropped");

   // frame position of the bit the modulator takes next, so the checks
   // see what leaves the buffer rather than the constant frame
   logic [5:0] out_idx_r;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) out_idx_r <= 6'h3F;
      else if (out_ready) out_idx_r <= out_idx_r - 1'b1;
   end

   sequence header_take_s;
      out_ready && out_idx_r > 6'h36;
   endsequence
   header_ones_a: assert property (@(posedge mclk)
      disable iff (!resetn) header_take_s |=> field_load_r)
      else $error("header not one");

   // stop bit low on the field
   stop_zero_a: assert property (@(posedge mclk)
      disable iff (!resetn) out_ready && out_idx_r == 6'h00 |=> !field_load_r)
      else $error("stop not zero");

   // bit time over: the next bit must already wait in the buffer
   sequence bit_end_s;
      busy_r && car_rise && per_cnt_r == 8'(BIT_PERIODS - 1);
   endsequence
   bit_gapless_a: assert property (@(posedge mclk)
      disable iff (!resetn) bit_end_s |-> out_valid)
      else $error("bit buffer ran dry");

   // load level holds for the bit time
   load_steady_a: assert property (@(posedge mclk)
      disable iff (!resetn) !out_ready && !(busy_r && car_rise) |=>
      $stable(field_load_r)) else $error("load changed mid bit");
endmodule : id_frame_tx
`default_nettype wire

// ==== verif/reader_field.sv ====
// reader device model: switches the field and makes the carrier
`timescale 1ns/100ps
`default_nettype none
module reader_field #(
   parameter int HALF_NS = 200,
   parameter int PHASE_NS = 137
) (
   input wire logic field_on,
   output logic carrier
);
   // ----------------------------------------
   // carrier generation
   // ----------------------------------------
   // carrier feeds tag
   // the carrier exists only while the field is on, so it rests low when off
   initial begin
      carrier = 1'b0;
      #(PHASE_NS); // phase unrelated to the bench clock
      forever begin
         #(HALF_NS);
         carrier = field_on ? ~carrier : 1'b0;
      end
   end
endmodule : reader_field
`default_nettype wire

// ==== verif/readonly_id_frame_transmitter_bench.sv ====
// self-checking bench for the id frame transmitter
`timescale 1ns/100ps
`default_nettype none
module readonly_id_frame_transmitter_bench;
   import id_frame_pkg::*;
   localparam logic [7:0] VER = 8'h5C;
   localparam logic [31:0] PAY = 32'h8E17F0A3;
   logic mclk, resetn, field_on, carrier_in, field_load_r, sending_r;
   int n_fail, cmp_count;
   logic [63:0] exp_frame;

   // ----------------------------------------
   // design and reader model
   // ----------------------------------------
   // two carrier periods per bit keeps the run short
   id_frame_tx #(.CONTENT({VER, PAY}), .BIT_PERIODS(2)) u_dut (
      .mclk(mclk),
      .resetn(resetn),
      .carrier_in(carrier_in),
      .field_load_r(field_load_r),
      .sending_r(sending_r)
   );
   reader_field u_field (.field_on(field_on), .carrier(carrier_in));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // frame worked out from content: header, rows with parity, columns, stop
   function automatic logic [63:0] build_frame(input logic [7:0] v,
                                               input logic [31:0] d);
      logic [63:0] f;
      logic [3:0] col;
      f = {45'h0, 9'h1FF, v[7:4], ^v[7:4], v[3:0], ^v[3:0]};
      col = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         f = {f[58:0], d[i*4+:4], ^d[i*4+:4]};
         col = col ^ d[i*4+:4];
      end
      build_frame = {f[58:0], col, 1'b0};
   endfunction : build_frame

   // move off the edge so outputs have settled
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : step

   task automatic check(input string what, input logic [63:0] exp,
                        input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // counts carrier rises from field-on until the first bit appears
   task automatic t_startup;
      int rises;
      logic prev;
      logic early;
      logic in_range;
      rises = 0;
      prev = carrier_in;
      early = 1'b0;
      while (sending_r !== 1'b1 && rises < 500) begin
         step(1);
         if (carrier_in === 1'b1 && prev === 1'b0) rises++;
         prev = carrier_in;
         if (sending_r !== 1'b1 && field_load_r !== 1'b0) early = 1'b1;
      end
      in_range = rises >= 250 && rises <= 400;
      check("startup rises", 64'(1), 64'(in_range));
      check("load before start", 64'(0), 64'(early));
   endtask : t_startup

   // samples mid-bit: one bit is 16 clocks, the first starts now
   task automatic t_frames(input int n);
      logic [63:0] got;
      step(8);
      for (int k = 0; k < n; k++) begin
         for (int b = 63; b >= 0; b--) begin
            got[b] = field_load_r;
            step(16);
         end
         check("head", 64'(exp_frame[63:45]), 64'(got[63:45]));
         check("frame", exp_frame, got);
         check("still sending", 64'(1), {63'(0), sending_r});
      end
   endtask : t_frames

   // field drops mid-frame, then returns: same wait, same frame again
   task automatic t_refield;
      step(100);
      field_on = 1'b0;
      resetn = 1'b0;
      step(4);
      check("off outputs", 64'(0), {62'(0), sending_r, field_load_r});
      field_on = 1'b1;
      resetn = 1'b1;
      t_startup();
      t_frames(1);
   endtask : t_refield

   // ----------------------------------------
   // clock, sequence and watchdog
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial begin
      n_fail = 0;
      cmp_count = 0;
      resetn = 1'b0;
      field_on = 1'b1;
      exp_frame = build_frame(VER, PAY);
      step(4);
      resetn = 1'b1;
      t_startup();
      t_frames(2);
      t_refield();
      end_sim();
   end

   // run needs about 8100 clocks; a hang is cut at 30000
   initial begin
      step(30000);
      n_fail++;
      end_sim();
   end
endmodule : readonly_id_frame_transmitter_bench
`default_nettype wire
